// file: core/uie_defines.vh
`ifndef UIE_DEFINES_VH
`define UIE_DEFINES_VH
// Register byte offsets on the AXI4-Lite slave
`define UIE_OFF_IEN_A   8'h00
`define UIE_OFF_FCR_A   8'h04
`define UIE_OFF_IID_A   8'h08
`define UIE_OFF_LSR_A   8'h0C
`define UIE_OFF_IEN_B   8'h10
`define UIE_OFF_FCR_B   8'h14
`define UIE_OFF_IID_B   8'h18
`define UIE_OFF_LSR_B   8'h1C
// Interrupt enable fields
`define UIE_IEN_RX      0
`define UIE_IEN_TX      1
`define UIE_IEN_LS      2
`define UIE_IEN_MS      3
`define UIE_IEN_RST     4'h0
// FIFO control fields
`define UIE_FCR_EN      0
`define UIE_FCR_DMA     3
`define UIE_FCR_RST     8'h00
// Identification codes, bits 3:0
`define UIE_ID_NONE     4'h1
`define UIE_ID_LS       4'h6
`define UIE_ID_RX       4'h4
`define UIE_ID_TX       4'h2
`define UIE_ID_MS       4'h0
// Bus answers
`define UIE_RESP_OKAY   2'h0
`define UIE_RESP_SLVERR 2'h2
`define UIE_FIFO_DEPTH  5'h10
`endif

// file: core/uie_top.v
`timescale 1ns/1ps
`include "uie_defines.vh"

////////////////////////////////////////////////////////////////////////////////
module uie_chan (
    clk,
    rst_n,
    ien_wr,
    fcr_wr,
    wdata,
    iid_rd,
    tx_wr,
    tx_count,
    tsr_empty,
    rx_count,
    rx_level,
    rx_err_any,
    ls_err,
    ms_delta,
    ien_q,
    fcr_q,
    iid_q,
    lsr_q,
    irq,
    tx_ready_out_n,
    rx_ready_out_n
);
    input            clk;
    input            rst_n;
    input            ien_wr;
    input            fcr_wr;
    input      [7:0] wdata;
    input            iid_rd;
    input            tx_wr;
    input      [4:0] tx_count;
    input            tsr_empty;
    input      [4:0] rx_count;
    input      [4:0] rx_level;
    input            rx_err_any;
    input      [3:0] ls_err;
    input      [3:0] ms_delta;
    output     [3:0] ien_q;
    output     [7:0] fcr_q;
    output     [7:0] iid_q;
    output     [7:0] lsr_q;
    output           irq;
    output           tx_ready_out_n;
    output           rx_ready_out_n;

    reg        [3:0] ien_r;
    reg        [7:0] fcr_r;
    reg              tx_irq_r;
    reg              tx_empty_d_r;
    reg              tx_empty_irq_n_r;
    reg              rx_ready_irq_n_r;
    reg        [7:0] iid_r;
    reg        [3:0] id_nxt;

    wire fifo_en  = fcr_r[`UIE_FCR_EN];
    wire dma1     = fifo_en & fcr_r[`UIE_FCR_DMA];
    wire tx_empty = (tx_count == 5'h00);
    wire rx_has   = (rx_count != 5'h00);
    wire tx_full  = (tx_count == `UIE_FIFO_DEPTH);
    // Character mode is a one-deep FIFO, so count>=1 means holding data
    wire rx_trig  = fifo_en ? (rx_count >= rx_level) : rx_has;
    wire tx_empty_rise = tx_empty & ~tx_empty_d_r;

    wire ms_int = ien_r[`UIE_IEN_MS] & (|ms_delta);
    wire ls_int = ien_r[`UIE_IEN_LS] & (|ls_err);
    wire rx_int = ien_r[`UIE_IEN_RX] & rx_trig;
    wire tx_int = ien_r[`UIE_IEN_TX] & tx_irq_r;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ien_r        <= `UIE_IEN_RST;
            fcr_r        <= `UIE_FCR_RST;
            tx_irq_r     <= 1'b0;
            tx_empty_d_r <= 1'b0;
            tx_empty_irq_n_r    <= 1'b1;
            rx_ready_irq_n_r    <= 1'b1;
        end else begin
            if (ien_wr)
                ien_r <= wdata[3:0];
            if (fcr_wr)
                fcr_r <= {wdata[7:6], 2'b00, wdata[3:0]};
            tx_empty_d_r <= tx_empty;
            // New emptiness wins over a clear in the same cycle
            if (tx_empty_rise)
                tx_irq_r <= 1'b1;
            else if (iid_rd | tx_wr)
                tx_irq_r <= 1'b0;
            else if (!tx_empty)
                tx_irq_r <= 1'b0;
            if (dma1)
                tx_empty_irq_n_r <= tx_full;
            else if (tx_empty)
                tx_empty_irq_n_r <= 1'b0;
            else if (tx_wr)
                tx_empty_irq_n_r <= 1'b1;
            if (!rx_has)
                rx_ready_irq_n_r <= 1'b1;
            else if (dma1 ? rx_trig : 1'b1)
                rx_ready_irq_n_r <= 1'b0;
        end
    end

    always @* begin
        if (ls_int)
            id_nxt = `UIE_ID_LS;
        else if (rx_int)
            id_nxt = `UIE_ID_RX;
        else if (tx_int)
            id_nxt = `UIE_ID_TX;
        else if (ms_int)
            id_nxt = `UIE_ID_MS;
        else
            id_nxt = `UIE_ID_NONE;
    end

    always @* begin
        iid_r = {fifo_en, fifo_en, 2'b00, id_nxt};
    end

    assign ien_q = ien_r;
    assign fcr_q = fcr_r;
    assign iid_q = iid_r;
    assign lsr_q = {rx_err_any & fifo_en,
                    tx_empty & tsr_empty,
                    tx_empty,
                    ls_err,
                    rx_has};
    assign irq = ms_int | ls_int | rx_int | tx_int;
    assign tx_ready_out_n = tx_empty_irq_n_r;
    assign rx_ready_out_n = rx_ready_irq_n_r;
endmodule // uie_chan

////////////////////////////////////////////////////////////////////////////////
module uie_top (
    clk,
    nrst,
    s_axi_awaddr,
    s_axi_awvalid,
    s_axi_awready,
    s_axi_wdata,
    s_axi_wstrb,
    s_axi_wvalid,
    s_axi_wready,
    s_axi_bresp,
    s_axi_bvalid,
    s_axi_bready,
    s_axi_araddr,
    s_axi_arvalid,
    s_axi_arready,
    s_axi_rdata,
    s_axi_rresp,
    s_axi_rvalid,
    s_axi_rready,
    tx_wr_a,
    tx_count_a,
    tsr_empty_a,
    rx_count_a,
    rx_level_a,
    rx_err_a,
    ls_err_a,
    ms_delta_a,
    tx_wr_b,
    tx_count_b,
    tsr_empty_b,
    rx_count_b,
    rx_level_b,
    rx_err_b,
    ls_err_b,
    ms_delta_b,
    irq_out_chan_a,
    irq_out_chan_b,
    tx_ready_out_n_a,
    rx_ready_out_n_a,
    tx_ready_out_n_b,
    rx_ready_out_n_b,
    rx_trig_sel_a,
    rx_trig_sel_b
);
    input             clk;
    input             nrst;
    input      [7:0]  s_axi_awaddr;
    input             s_axi_awvalid;
    output            s_axi_awready;
    input      [31:0] s_axi_wdata;
    input      [3:0]  s_axi_wstrb;
    input             s_axi_wvalid;
    output            s_axi_wready;
    output     [1:0]  s_axi_bresp;
    output            s_axi_bvalid;
    input             s_axi_bready;
    input      [7:0]  s_axi_araddr;
    input             s_axi_arvalid;
    output            s_axi_arready;
    output     [31:0] s_axi_rdata;
    output     [1:0]  s_axi_rresp;
    output            s_axi_rvalid;
    input             s_axi_rready;
    input             tx_wr_a;
    input      [4:0]  tx_count_a;
    input             tsr_empty_a;
    input      [4:0]  rx_count_a;
    input      [4:0]  rx_level_a;
    input             rx_err_a;
    input      [3:0]  ls_err_a;
    input      [3:0]  ms_delta_a;
    input             tx_wr_b;
    input      [4:0]  tx_count_b;
    input             tsr_empty_b;
    input      [4:0]  rx_count_b;
    input      [4:0]  rx_level_b;
    input             rx_err_b;
    input      [3:0]  ls_err_b;
    input      [3:0]  ms_delta_b;
    output            irq_out_chan_a;
    output            irq_out_chan_b;
    output            tx_ready_out_n_a;
    output            rx_ready_out_n_a;
    output            tx_ready_out_n_b;
    output            rx_ready_out_n_b;
    output     [1:0]  rx_trig_sel_a;
    output     [1:0]  rx_trig_sel_b;

    reg        [1:0]  rst_sync_r;
    reg        [7:0]  awaddr_r;
    reg               aw_have_r;
    reg        [7:0]  wdata_r;
    reg               w_have_r;
    reg               w_lane_r;
    reg               bvalid_r;
    reg        [1:0]  bresp_r;
    reg               rvalid_r;
    reg        [31:0] rdata_r;
    reg        [1:0]  rresp_r;
    reg        [31:0] rd_mux;
    reg               rd_ok;

    wire       rst_n = rst_sync_r[1];
    wire [3:0] ien_a, ien_b;
    wire [7:0] fcr_a, fcr_b, iid_a, iid_b, lsr_a, lsr_b;

    always @(posedge clk or negedge nrst) begin
        if (!nrst)
            rst_sync_r <= 2'b00;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end

    ////////////////////////////////////////////////////////////////////////
    // Write path: address and data may arrive in either order
    wire wr_go  = aw_have_r & w_have_r & ~bvalid_r;
    wire wr_ien_a = wr_go & (awaddr_r == `UIE_OFF_IEN_A);
    wire wr_fcr_a = wr_go & (awaddr_r == `UIE_OFF_FCR_A);
    wire wr_ien_b = wr_go & (awaddr_r == `UIE_OFF_IEN_B);
    wire wr_fcr_b = wr_go & (awaddr_r == `UIE_OFF_FCR_B);
    wire wr_ok  = wr_ien_a | wr_fcr_a | wr_ien_b | wr_fcr_b;
    wire rd_go  = s_axi_arvalid & ~rvalid_r;

    assign s_axi_awready = ~aw_have_r & ~bvalid_r;
    assign s_axi_wready  = ~w_have_r & ~bvalid_r;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            awaddr_r  <= 8'h00;
            aw_have_r <= 1'b0;
            wdata_r   <= 8'h00;
            w_have_r  <= 1'b0;
            w_lane_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `UIE_RESP_OKAY;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                awaddr_r  <= {s_axi_awaddr[7:2], 2'b00};
                aw_have_r <= 1'b1;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                // Only byte lane 0 carries register bits
                wdata_r  <= s_axi_wdata[7:0];
                w_have_r <= 1'b1;
                // Lane 0 off: still answered, register left alone
                w_lane_r <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_have_r <= 1'b0;
                w_have_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_ok ? `UIE_RESP_OKAY : `UIE_RESP_SLVERR;
            end else if (bvalid_r & s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path: identification reads clear a pending transmit interrupt
    wire rd_iid_a = rd_go & ({s_axi_araddr[7:2], 2'b00} == `UIE_OFF_IID_A);
    wire rd_iid_b = rd_go & ({s_axi_araddr[7:2], 2'b00} == `UIE_OFF_IID_B);

    always @* begin
        rd_ok  = 1'b1;
        rd_mux = 32'h0000_0000;
        case ({s_axi_araddr[7:2], 2'b00})
            `UIE_OFF_IEN_A: rd_mux = {28'h0000000, ien_a};
            `UIE_OFF_FCR_A: rd_mux = {24'h000000, fcr_a};
            `UIE_OFF_IID_A: rd_mux = {24'h000000, iid_a};
            `UIE_OFF_LSR_A: rd_mux = {24'h000000, lsr_a};
            `UIE_OFF_IEN_B: rd_mux = {28'h0000000, ien_b};
            `UIE_OFF_FCR_B: rd_mux = {24'h000000, fcr_b};
            `UIE_OFF_IID_B: rd_mux = {24'h000000, iid_b};
            `UIE_OFF_LSR_B: rd_mux = {24'h000000, lsr_b};
            default:        rd_ok  = 1'b0;
        endcase
    end

    assign s_axi_arready = ~rvalid_r;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= `UIE_RESP_OKAY;
        end else if (rd_go) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_mux;
            rresp_r  <= rd_ok ? `UIE_RESP_OKAY : `UIE_RESP_SLVERR;
        end else if (rvalid_r & s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp  = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata  = rdata_r;
    assign s_axi_rresp  = rresp_r;
    assign rx_trig_sel_a = fcr_a[7:6];
    assign rx_trig_sel_b = fcr_b[7:6];

    ////////////////////////////////////////////////////////////////////////
    // Separate instances keep the channels free of shared state
    uie_chan u_chan_a (
        .clk            (clk),
        .rst_n          (rst_n),
        .ien_wr         (wr_ien_a & w_lane_r),
        .fcr_wr         (wr_fcr_a & w_lane_r),
        .wdata          (wdata_r),
        .iid_rd         (rd_iid_a),
        .tx_wr          (tx_wr_a),
        .tx_count       (tx_count_a),
        .tsr_empty      (tsr_empty_a),
        .rx_count       (rx_count_a),
        .rx_level       (rx_level_a),
        .rx_err_any     (rx_err_a),
        .ls_err         (ls_err_a),
        .ms_delta       (ms_delta_a),
        .ien_q          (ien_a),
        .fcr_q          (fcr_a),
        .iid_q          (iid_a),
        .lsr_q          (lsr_a),
        .irq            (irq_out_chan_a),
        .tx_ready_out_n (tx_ready_out_n_a),
        .rx_ready_out_n (rx_ready_out_n_a)
    );

    uie_chan u_chan_b (
        .clk            (clk),
        .rst_n          (rst_n),
        .ien_wr         (wr_ien_b & w_lane_r),
        .fcr_wr         (wr_fcr_b & w_lane_r),
        .wdata          (wdata_r),
        .iid_rd         (rd_iid_b),
        .tx_wr          (tx_wr_b),
        .tx_count       (tx_count_b),
        .tsr_empty      (tsr_empty_b),
        .rx_count       (rx_count_b),
        .rx_level       (rx_level_b),
        .rx_err_any     (rx_err_b),
        .ls_err         (ls_err_b),
        .ms_delta       (ms_delta_b),
        .ien_q          (ien_b),
        .fcr_q          (fcr_b),
        .iid_q          (iid_b),
        .lsr_q          (lsr_b),
        .irq            (irq_out_chan_b),
        .tx_ready_out_n (tx_ready_out_n_b),
        .rx_ready_out_n (rx_ready_out_n_b)
    );
endmodule // uie_top

// file: bench/uie_dma_model.sv
`timescale 1ns/1ps
module uie_dma_model (
    input  logic       clk,
    input  logic       rst_n,
    input  logic       run,
    input  logic       drain,
    input  logic       tx_ready_out_n,
    output logic       tx_wr,
    output logic [4:0] tx_count
);
    // No write while the last pulse is out: ready is registered and lags
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_wr    <= 1'b0;
            tx_count <= 5'h00;
        end else if (run && !tx_ready_out_n && !tx_wr
                     && tx_count != 5'h10) begin
            tx_wr    <= 1'b1;
            tx_count <= tx_count + 5'h01;
        end else begin
            tx_wr <= 1'b0;
            if (drain && tx_count != 5'h00)
                tx_count <= tx_count - 5'h01;
        end
    end
endmodule // uie_dma_model

// file: bench/uie_properties.sv
`timescale 1ns/1ps
`include "uie_defines.vh"
module uie_properties (
    input logic        clk,
    input logic        nrst,
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic [1:0]  s_axi_bresp,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic [7:0]  s_axi_araddr,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0]  s_axi_rresp,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic        tx_wr_a,
    input logic [4:0]  tx_count_a,
    input logic [4:0]  rx_count_a,
    input logic        irq_out_chan_a,
    input logic        irq_out_chan_b,
    input logic        tx_ready_out_n_a,
    input logic        rx_ready_out_n_a
);
    logic [2:0] rel_r;
    logic       quiet_r;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Ready pins are held inactive until the internal reset copy lets go
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rel_r   <= 3'h0;
            quiet_r <= 1'b1;
        end else begin
            if (rel_r != 3'h4)
                rel_r <= rel_r + 3'h1;
            if (s_axi_awvalid && s_axi_awready)
                quiet_r <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    a_irq_quiet: assert property (
        quiet_r |-> !irq_out_chan_a && !irq_out_chan_b)
        else $error("irq before any enable write");
    a_rx_idle_hi: assert property (
        rel_r == 3'h4 && rx_count_a == 5'h00 |=> rx_ready_out_n_a)
        else $error("rx ready low with empty fifo");
    a_tx_empty_lo: assert property (
        rel_r == 3'h4 && tx_count_a == 5'h00 && !tx_wr_a
        |=> !tx_ready_out_n_a)
        else $error("tx ready high with empty fifo");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped early");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped early");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    a_bad_read: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr[7:5] != 3'h0 |=> s_axi_rresp == `UIE_RESP_SLVERR)
        else $error("unmapped read not refused");
    c_irq: cover property (irq_out_chan_a);
    c_tx_full: cover property (tx_count_a == 5'h10 && tx_ready_out_n_a);
    c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule // uie_properties

bind uie_top uie_properties u_props (.*);

// file: bench/tb_uart_interrupt_enable_dma_ready.sv
`timescale 1ns/1ps
`include "uie_defines.vh"
module tb_uart_interrupt_enable_dma_ready;
    logic        clk = 1'b0, nrst = 1'b0, run = 1'b0, drain = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, tx_wr_b = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, tx_wr_a;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rx_trig_sel_a, rx_trig_sel_b;
    logic [4:0]  tx_count_a, tx_count_b = 5'h00;
    logic        tsr_empty_a = 1'b1, tsr_empty_b = 1'b1;
    logic [4:0]  rx_count_a = 5'h00, rx_count_b = 5'h00;
    logic [4:0]  rx_level_a = 5'h01, rx_level_b = 5'h01;
    logic        rx_err_a = 1'b0, rx_err_b = 1'b0;
    logic [3:0]  ls_err_a = 4'h0, ls_err_b = 4'h0;
    logic [3:0]  ms_delta_a = 4'h0, ms_delta_b = 4'h0;
    logic        irq_out_chan_a, irq_out_chan_b;
    logic        tx_ready_out_n_a, rx_ready_out_n_a;
    logic        tx_ready_out_n_b, rx_ready_out_n_b;
    int          fails = 0, total_checks = 0;

    uie_top dut (.*);
    uie_dma_model u_dma (.clk(clk), .rst_n(nrst), .run(run), .drain(drain),
        .tx_ready_out_n(tx_ready_out_n_a), .tx_wr(tx_wr_a),
        .tx_count(tx_count_a));

    initial forever #20 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Sample at the falling edge so readies seen are those of the next rise
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic [1:0] er = `UIE_RESP_OKAY);
        logic ha, hw;
        ha = 1'b0;
        hw = 1'b0;
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        while (!(ha && hw)) begin
            @(negedge clk);
            ha = ha || s_axi_awready;
            hw = hw || s_axi_wready;
            @(posedge clk);
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
        end
        @(posedge clk);
        s_axi_bready <= 1'b1;
        do @(negedge clk); while (!s_axi_bvalid);
        chk(s_axi_bresp, er);
        @(posedge clk);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er = `UIE_RESP_OKAY);
        logic ha;
        ha = 1'b0;
        @(posedge clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        while (!ha) begin
            @(negedge clk);
            ha = s_axi_arready;
            @(posedge clk);
        end
        s_axi_arvalid <= 1'b0;
        @(posedge clk);
        s_axi_rready <= 1'b1;
        do @(negedge clk); while (!s_axi_rvalid);
        if (er == `UIE_RESP_OKAY) chk(s_axi_rdata, e);
        chk(s_axi_rresp, er);
        @(posedge clk);
        s_axi_rready <= 1'b0;
    endtask
    task gap;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask
    task t_sources;
        logic [7:0] ids [4];
        ids = '{8'h04, 8'h01, 8'h06, 8'h00};
        rd(`UIE_OFF_IEN_A, 32'h00);
        rd(`UIE_OFF_IID_A, 32'h01);
        rd(`UIE_OFF_LSR_A, 32'h60);
        rd(8'h20, 32'h00, `UIE_RESP_SLVERR);
        wr(8'h20, 8'h0F, `UIE_RESP_SLVERR);
        wr(`UIE_OFF_IEN_A, 8'h02);
        @(posedge clk);
        run <= 1'b1;
        gap;
        @(posedge clk);
        run   <= 1'b0;
        drain <= 1'b1;
        gap;
        chk(irq_out_chan_a, 1'b1);
        rd(`UIE_OFF_IID_A, 32'h02);
        gap;
        chk(irq_out_chan_a, 1'b0);
        @(posedge clk);
        rx_count_a <= 5'h01;
        ls_err_a   <= 4'h4;
        ms_delta_a <= 4'h8;
        for (int i = 0; i < 4; i++) begin
            wr(`UIE_OFF_IEN_A, 8'h01 << i);
            gap;
            chk(irq_out_chan_a, i != 1);
            chk(irq_out_chan_b, 1'b0);
            rd(`UIE_OFF_IID_A, ids[i]);
        end
        wr(`UIE_OFF_IEN_A, 8'h00);
        // Lane 0 strobe off: answered, but the enables must not move
        s_axi_wstrb <= 4'hE;
        wr(`UIE_OFF_IEN_A, 8'h0F);
        s_axi_wstrb <= 4'hF;
        rd(`UIE_OFF_IEN_A, 32'h00);
        rd(`UIE_OFF_LSR_A, 32'h69);
    endtask
    task t_fifo;
        wr(`UIE_OFF_FCR_A, 8'hC1);
        wr(`UIE_OFF_IEN_A, 8'h01);
        chk(rx_trig_sel_a, 2'h3);
        ls_err_a   <= 4'h0;
        ms_delta_a <= 4'h0;
        rx_level_a <= 5'h04;
        rx_count_a <= 5'h03;
        rx_err_a   <= 1'b1;
        gap;
        chk(irq_out_chan_a, 1'b0);
        rd(`UIE_OFF_LSR_A, 32'hE1);
        rx_count_a <= 5'h04;
        gap;
        chk(irq_out_chan_a, 1'b1);
        rd(`UIE_OFF_IID_A, 32'hC4);
        rx_count_a  <= 5'h03;
        tsr_empty_a <= 1'b0;
        gap;
        chk(irq_out_chan_a, 1'b0);
        rd(`UIE_OFF_IID_A, 32'hC1);
        rd(`UIE_OFF_LSR_A, 32'hA1);
        wr(`UIE_OFF_IEN_A, 8'h00);
        rx_count_a <= 5'h10;
        gap;
        chk(irq_out_chan_a, 1'b0);
    endtask
    task t_dma;
        @(posedge clk);
        rx_count_a  <= 5'h00;
        tsr_empty_a <= 1'b1;
        drain       <= 1'b0;
        run         <= 1'b1;
        repeat (3) gap;
        chk(tx_count_a, 5'h01);
        chk(tx_ready_out_n_a, 1'b1);
        @(posedge clk);
        rx_count_a <= 5'h01;
        gap;
        chk(rx_ready_out_n_a, 1'b0);
        @(posedge clk);
        rx_count_a <= 5'h00;
        wr(`UIE_OFF_FCR_A, 8'hC9);
        rx_count_a <= 5'h03;
        repeat (40) @(posedge clk);
        chk(tx_count_a, 5'h10);
        chk(tx_ready_out_n_a, 1'b1);
        chk(rx_ready_out_n_a, 1'b1);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            rx_count_a <= (i == 0) ? 5'h04 : 5'(2 - i);
            gap;
            chk(rx_ready_out_n_a, i == 2);
        end
    endtask
    task t_chan_b;
        wr(`UIE_OFF_IEN_B, 8'h08);
        ms_delta_b  <= 4'h1;
        ls_err_b    <= 4'h1;
        rx_count_b  <= 5'h02;
        rx_level_b  <= 5'h02;
        rx_err_b    <= 1'b1;
        tsr_empty_b <= 1'b0;
        gap;
        chk(irq_out_chan_b, 1'b1);
        chk(irq_out_chan_a, 1'b0);
        chk(tx_ready_out_n_b, 1'b0);
        chk(rx_ready_out_n_b, 1'b0);
        rd(`UIE_OFF_IID_B, 32'h00);
        rd(`UIE_OFF_LSR_B, 32'h23);
        // Bits 5:4 of the FIFO control word always read back zero
        wr(`UIE_OFF_FCR_B, 8'hB9);
        rd(`UIE_OFF_FCR_B, 32'h89);
        chk(rx_trig_sel_b, 2'h2);
        chk(rx_trig_sel_a, 2'h3);
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        t_sources;
        t_fifo;
        t_dma;
        t_chan_b;
        close_out;
    end
    // Whole run is a few hundred cycles; this span is far beyond it
    initial begin
        #2000000;
        fails++;
        close_out;
    end
endmodule // tb_uart_interrupt_enable_dma_ready
